// >>> eeprom_host_regs.svh
`ifndef EEPROM_HOST_REGS_SVH
`define EEPROM_HOST_REGS_SVH
`define CLK_NS 100
`define ADDR_W 15
`define DATA_W 8
`define PAGE_BYTES 64
`define READ_CYCLE_NS 300
`define READ_CYC ((`READ_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_NS 100
`define RECOVER_CYC ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`define PROTECT_RECOVERY_US 1
`define PROTECT_RECOVERY_CYC ((`PROTECT_RECOVERY_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define BYTE_LOAD_MIN_US 1
`define BYTE_LOAD_MIN_CYC ((`BYTE_LOAD_MIN_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define BYTE_LOAD_MAX_US 100
`define BYTE_LOAD_MAX_CYC ((`BYTE_LOAD_MAX_US * 1000) / `CLK_NS)
`define PROGRAM_TIME_MS 10
`define PROGRAM_TIME_CYC ((`PROGRAM_TIME_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`define POWERUP_READ_US 100
`define POWERUP_READ_CYC ((`POWERUP_READ_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define POWERUP_WRITE_MS 5
`define POWERUP_WRITE_CYC ((`POWERUP_WRITE_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`define TIMER_W 17
`endif

// >>> eeprom_host_pkg.sv
package eeprom_host_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_READ = 7'h02,
    ST_WSET = 7'h04,
    ST_WSTROBE = 7'h08,
    ST_WREC = 7'h10,
    ST_PAGEWAIT = 7'h20,
    ST_PROGWAIT = 7'h40
  } state_t;
endpackage : eeprom_host_pkg

// >>> wait_timer.sv
`timescale 1ns/1ps
`include "eeprom_host_regs.svh"
// Down counter; load wins over count, done is level while zero
module wait_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [`TIMER_W-1:0] loadVal,
  output logic done
);
  logic [`TIMER_W-1:0] count_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_ff <= 17'h00000;
    end else if (clkEn) begin
      if (load) begin
        count_ff <= loadVal;
      end else if (count_ff != 17'h00000) begin
        count_ff <= count_ff - 17'h00001;
      end
    end
  end
  assign done = (count_ff == 17'h00000);
endmodule : wait_timer

// >>> eeprom_host.sv
`timescale 1ns/1ps
`include "eeprom_host_regs.svh"
// Host controller for a byte-wide self-timed EEPROM
module eeprom_host #(
  parameter int unsigned PROGRAM_CYC = `PROGRAM_TIME_CYC,
  parameter int unsigned PWR_WRITE_CYC = `POWERUP_WRITE_CYC,
  parameter int unsigned PWR_READ_CYC = `POWERUP_READ_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqLast,
  input wire logic reqProtect,
  input wire logic [`ADDR_W-1:0] reqAddr,
  input wire logic [`DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [`DATA_W-1:0] rspData,
  output logic busy,
  output logic [`ADDR_W-1:0] memAddr,
  output logic chipSel_n,
  output logic outDrive_n,
  output logic store_n,
  input wire logic [`DATA_W-1:0] dataIn,
  output logic [`DATA_W-1:0] dataOut,
  output logic dataOe
);
  eeprom_host_pkg::state_t state_ff;
  logic [`TIMER_W-1:0] cnt_ff;
  logic [`TIMER_W-1:0] pwrCnt_ff;
  logic readOk_ff;
  logic writeOk_ff;
  logic protectTail_ff;
  logic progLoad;
  logic progDone;
  logic [`TIMER_W-1:0] progVal;
  logic [`TIMER_W-1:0] pageCnt_ff;
  logic reqLast_ff;
  logic accept;

  // Power-up gates: reads after 100 us, writes after 5 ms
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwrCnt_ff <= 17'h00000;
      readOk_ff <= 1'b0;
      writeOk_ff <= 1'b0;
    end else if (clkEn) begin
      if (!writeOk_ff) begin
        pwrCnt_ff <= pwrCnt_ff + 17'h00001;
      end
      if (pwrCnt_ff >= PWR_READ_CYC[`TIMER_W-1:0]) begin
        readOk_ff <= 1'b1;
      end
      if (pwrCnt_ff >= PWR_WRITE_CYC[`TIMER_W-1:0]) begin
        writeOk_ff <= 1'b1;
      end
    end
  end

  assign progVal = PROGRAM_CYC[`TIMER_W-1:0];
  assign progLoad = clkEn && (state_ff == eeprom_host_pkg::ST_PAGEWAIT)
                    && (pageCnt_ff == 17'h00000);

  // Full program time after the last page load, no polling used
  wait_timer u_prog (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .load(progLoad),
    .loadVal(progVal),
    .done(progDone)
  );

  // Taken in idle once its power-up gate opened, or as the next byte of an open page
  assign reqReady = ((state_ff == eeprom_host_pkg::ST_IDLE)
                     && (reqWrite ? writeOk_ff : readOk_ff))
                    || ((state_ff == eeprom_host_pkg::ST_PAGEWAIT) && reqWrite && writeOk_ff
                        && (pageCnt_ff != 17'h00000));
  assign busy = (state_ff != eeprom_host_pkg::ST_IDLE);

  // Sequencer: read cycle, write strobe, byte-load window, program wait
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= eeprom_host_pkg::ST_IDLE;
      cnt_ff <= 17'h00000;
      pageCnt_ff <= 17'h00000;
      protectTail_ff <= 1'b0;
    end else if (clkEn) begin
      case (state_ff)
        eeprom_host_pkg::ST_IDLE: begin
          if (reqValid && reqReady) begin
            state_ff <= reqWrite ? eeprom_host_pkg::ST_WSET : eeprom_host_pkg::ST_READ;
            cnt_ff <= reqWrite ? 17'h00001 : 17'(`READ_CYC);
            protectTail_ff <= reqWrite && reqProtect;
          end
        end
        eeprom_host_pkg::ST_READ: begin
          if (cnt_ff == 17'h00001) begin
            state_ff <= eeprom_host_pkg::ST_IDLE;
          end
          cnt_ff <= cnt_ff - 17'h00001;
        end
        eeprom_host_pkg::ST_WSET: begin
          // One cycle of address and data setup with output drive high
          state_ff <= eeprom_host_pkg::ST_WSTROBE;
          cnt_ff <= 17'(`STROBE_CYC);
        end
        eeprom_host_pkg::ST_WSTROBE: begin
          if (cnt_ff == 17'h00001) begin
            state_ff <= eeprom_host_pkg::ST_WREC;
            cnt_ff <= protectTail_ff ? 17'(`PROTECT_RECOVERY_CYC) : 17'(`BYTE_LOAD_MIN_CYC);
          end else begin
            cnt_ff <= cnt_ff - 17'h00001;
          end
        end
        eeprom_host_pkg::ST_WREC: begin
          // Store held high a byte-load minimum, also after each protect byte
          if (cnt_ff == 17'h00001) begin
            state_ff <= eeprom_host_pkg::ST_PAGEWAIT;
            // Window shrinks by the recovery so load-to-load spacing stays under the maximum
            if (reqLast_ff) begin
              pageCnt_ff <= 17'h00000;
            end else if (protectTail_ff) begin
              pageCnt_ff <= 17'(`BYTE_LOAD_MAX_CYC - `PROTECT_RECOVERY_CYC - 2);
            end else begin
              pageCnt_ff <= 17'(`BYTE_LOAD_MAX_CYC - `BYTE_LOAD_MIN_CYC - 2);
            end
          end else begin
            cnt_ff <= cnt_ff - 17'h00001;
          end
        end
        eeprom_host_pkg::ST_PAGEWAIT: begin
          // Next byte must come before the load window closes
          if (pageCnt_ff == 17'h00000) begin
            state_ff <= eeprom_host_pkg::ST_PROGWAIT;
          end else if (reqValid && reqWrite && writeOk_ff) begin
            state_ff <= eeprom_host_pkg::ST_WSET;
            protectTail_ff <= reqProtect;
          end else begin
            pageCnt_ff <= pageCnt_ff - 17'h00001;
          end
        end
        eeprom_host_pkg::ST_PROGWAIT: begin
          if (progDone && !progLoad) begin
            state_ff <= eeprom_host_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= eeprom_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Page-final flag captured when each byte is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reqLast_ff <= 1'b0;
    end else if (clkEn) begin
      if (accept) begin
        reqLast_ff <= reqLast;
      end
    end
  end

  // Taken only when the handshake completes, so the requester always sees it
  assign accept = clkEn && reqValid && reqReady;

  // Address and write data are latched on acceptance
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      memAddr <= 15'h0000;
      dataOut <= 8'h00;
    end else if (accept) begin
      memAddr <= reqAddr;
      dataOut <= reqData;
    end
  end

  // Pin strobes from state; select high outside cycles keeps standby
  // Drive never pulses without select, so no shared-bus fetch is made between loads
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chipSel_n <= 1'b1;
      outDrive_n <= 1'b1;
      store_n <= 1'b1;
      dataOe <= 1'b0;
    end else if (clkEn) begin
      chipSel_n <= 1'b1;
      outDrive_n <= 1'b1;
      store_n <= 1'b1;
      dataOe <= 1'b0;
      if (accept && !reqWrite) begin
        chipSel_n <= 1'b0;
        outDrive_n <= 1'b0;
      end else if ((state_ff == eeprom_host_pkg::ST_READ) && (cnt_ff != 17'h00001)) begin
        chipSel_n <= 1'b0;
        outDrive_n <= 1'b0;
      end else if (state_ff == eeprom_host_pkg::ST_WSET) begin
        chipSel_n <= 1'b0;
        store_n <= 1'b0;
        dataOe <= 1'b1;
      end else if ((state_ff == eeprom_host_pkg::ST_WSTROBE) && (cnt_ff != 17'h00001)) begin
        chipSel_n <= 1'b0;
        store_n <= 1'b0;
        dataOe <= 1'b1;
      end
    end
  end

  // Read data sampled on the last driven cycle, after device access time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData <= 8'h00;
    end else if (clkEn) begin
      rspValid <= (state_ff == eeprom_host_pkg::ST_READ) && (cnt_ff == 17'h00001);
      if ((state_ff == eeprom_host_pkg::ST_READ) && (cnt_ff == 17'h00001)) begin
        rspData <= dataIn;
      end
    end
  end

  // Store strobe never meets output drive low
  a_no_store_read: assert property (@(posedge sys_clk) disable iff (rst)
    !(!store_n && !outDrive_n)) else $error("store and output drive both low");

  // Host never drives data while the device may drive it
  a_bus_contention: assert property (@(posedge sys_clk) disable iff (rst)
    dataOe |-> (outDrive_n && !store_n)) else $error("data driven during read");

  // Write strobe only with select low
  a_store_selected: assert property (@(posedge sys_clk) disable iff (rst)
    !store_n |-> !chipSel_n) else $error("store without select");

  // No write before power-up gate
  a_powerup_write: assert property (@(posedge sys_clk) disable iff (rst)
    !writeOk_ff |-> store_n) else $error("write before power-up wait");

  // No read before power-up gate
  a_powerup_read: assert property (@(posedge sys_clk) disable iff (rst)
    !readOk_ff |-> outDrive_n) else $error("read before power-up wait");

  sequence s_prog_start;
    progLoad;
  endsequence
  // Program wait holds off new requests
  a_prog_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s_prog_start |=> !reqReady [*8]) else $error("request during program time");

  // Read response follows a read strobe
  a_read_resp: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(rspValid) |-> !$past(outDrive_n)) else $error("response without read");

  sequence s_store_pulse;
    !store_n ##1 store_n;
  endsequence
  // Store low lasts the one-cycle strobe width and then ends
  a_store_width: assert property (@(posedge sys_clk) disable iff (rst || !clkEn)
    $fell(store_n) |-> s_store_pulse) else $error("store strobe width wrong");
endmodule : eeprom_host

// >>> eeprom_model.sv
`timescale 1ns/1ps
`include "eeprom_host_regs.svh"
// Behavioural byte-wide array with self-timed programming; counts host timing faults
module eeprom_model #(
  parameter int PROG = 1900,
  parameter int PR = 10,
  parameter int PW = 30
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] memAddr,
  input wire logic chipSel_n,
  input wire logic outDrive_n,
  input wire logic store_n,
  input wire logic dataOe,
  input wire logic [`DATA_W-1:0] bus,
  output logic devOe,
  output logic [`DATA_W-1:0] devData,
  output int faults
);
  logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
  logic [`ADDR_W-1:0] wAddr;
  logic [`DATA_W-1:0] wData;
  logic [`DATA_W-1:0] lastData;
  logic wrPrev;
  int age;
  int gap;
  wire logic rdNow = !chipSel_n && !outDrive_n && store_n;
  wire logic wrNow = !chipSel_n && !store_n && outDrive_n;
  // Release is immediate, well inside the allowed delay
  assign devOe = rdNow;
  // While programming, reads return inverted status instead of array data
  assign devData = (gap < PROG) ? ~lastData : mem[memAddr];
  // A byte is committed when its strobe closes; a drive pulse alone leaves the page open
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age <= 0;
      gap <= PROG;
      wrPrev <= 1'b0;
      faults <= 0;
    end else begin
      age <= age + 1;
      gap <= gap + 1;
      wrPrev <= wrNow;
      if (wrNow) begin
        wAddr <= memAddr;
        wData <= bus;
      end
      if (wrPrev && !wrNow) begin
        mem[wAddr] <= wData;
        lastData <= wData;
        gap <= 0;
        if (gap < `BYTE_LOAD_MIN_CYC || (gap > `BYTE_LOAD_MAX_CYC && gap < PROG)) begin
          faults <= faults + 1;
        end
      end
      if ((wrNow && !wrPrev && age < PW) || (rdNow && age < PR) || (devOe && dataOe)) begin
        faults <= faults + 1;
      end
    end
  end
endmodule : eeprom_model

// >>> tb_top.sv
`timescale 1ns/1ps
`include "eeprom_host_regs.svh"
module tb_top;
  localparam int PROG_C = 2000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqLast = 1'b0;
  logic reqProtect = 1'b0;
  logic [`ADDR_W-1:0] reqAddr = 15'h0000;
  logic [`DATA_W-1:0] reqData = 8'h00;
  logic reqReady, rspValid, busy, chipSel_n, outDrive_n, store_n, dataOe, devOe;
  logic [`DATA_W-1:0] rspData, dataOut, devData, busIn;
  logic [`DATA_W-1:0] lastBus = 8'h00;
  logic [`ADDR_W-1:0] memAddr;
  int faults;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  eeprom_host #(.PROGRAM_CYC(PROG_C), .PWR_WRITE_CYC(30), .PWR_READ_CYC(10)) dut (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqLast(reqLast), .reqProtect(reqProtect), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .busy(busy),
    .memAddr(memAddr), .chipSel_n(chipSel_n), .outDrive_n(outDrive_n), .store_n(store_n),
    .dataIn(busIn), .dataOut(dataOut), .dataOe(dataOe));
  eeprom_model #(.PROG(PROG_C - 100), .PR(10), .PW(30)) mdl (
    .sys_clk(sys_clk), .rst(rst), .memAddr(memAddr), .chipSel_n(chipSel_n),
    .outDrive_n(outDrive_n), .store_n(store_n), .dataOe(dataOe), .bus(busIn),
    .devOe(devOe), .devData(devData), .faults(faults));
  // Undriven bus shows a changing pattern so a stale sample cannot pass
  assign busIn = dataOe ? dataOut : (devOe ? devData : ~lastBus);
  always #50 sys_clk = ~sys_clk;
  // Hang guard and bus history
  always @(posedge sys_clk) begin
    lastBus <= busIn;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // One request, held until the edge where it is accepted
  task automatic send(input logic wr, input logic last, input logic prot,
                      input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    reqWrite <= wr;
    reqLast <= last;
    reqProtect <= prot;
    reqAddr <= a;
    reqData <= d;
    reqValid <= 1'b1;
    @(negedge sys_clk);
    while (reqReady !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 5000, 1'b1);
    @(posedge sys_clk);
    reqValid <= 1'b0;
  endtask : send
  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp);
    send(1'b0, 1'b0, 1'b0, a, 8'h00);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(rspValid, 1'b0);
    @(negedge sys_clk);
    chk(rspValid, 1'b1);
    chk(rspData, exp);
  endtask : rd
  // A clock-enable pause in mid-read holds the strobes and delays the answer
  task automatic t_freeze(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp);
    send(1'b0, 1'b0, 1'b0, a, 8'h00);
    clkEn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({chipSel_n, outDrive_n, rspValid}, 3'h0);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(rspValid, 1'b0);
    @(negedge sys_clk);
    chk(rspValid, 1'b1);
    chk(rspData, exp);
    $display("test freeze done");
  endtask : t_freeze
  // Requests are refused until each power-up wait has passed
  task automatic t_gate();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(reqReady, 1'b0);
    chk({chipSel_n, outDrive_n, store_n, dataOe}, 4'hE);
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(reqReady, 1'b1);
    @(posedge sys_clk);
    reqWrite <= 1'b1;
    @(negedge sys_clk);
    chk(reqReady, 1'b0);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(reqReady, 1'b1);
    $display("test gate done");
  endtask : t_gate
  // Four-byte page; with prot the first three form the protect sequence
  task automatic t_page(input logic [`ADDR_W-1:0] base, input logic prot);
    int cnt;
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      send(1'b1, i == 3, prot && i < 3, base + 15'(i), base[7:0] ^ 8'(i));
    end
    @(negedge sys_clk);
    chk(busy, 1'b1);
    chk(reqReady, 1'b0);
    while (busy === 1'b1 && cnt < 5000) begin
      @(negedge sys_clk);
      cnt++;
    end
    chk(cnt >= PROG_C - 1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(base + 15'(i), base[7:0] ^ 8'(i));
    end
    $display("test page %0h done", base);
  endtask : t_page
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_gate();
    t_page(15'h0040, 1'b0);
    t_page(15'h1230, 1'b1);
    t_freeze(15'h1231, 8'h31);
    chk(faults, 0);
    give_verdict();
  end
endmodule : tb_top
